// ### bench/gcfp_dram_load.sv
// memory clock load: measures high and low widths of one copy
module gcfp_dram_load
   import gcfp_pkg::*;
(
   // load clock pins
   input  wire logic                           clk,
   input  wire logic [gcfp_pkg::BANK_WIDTH-1:0] ck,
   // measured widths in system cycles
   output logic      [7:0]                     hi_len,
   output logic      [7:0]                     lo_len
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] run_r = 8'h00;
   logic       prev_r = 1'b0;
   // widths only trusted once lock is seen
   always @(negedge clk) begin
      if (ck[0] !== prev_r) begin
         if (prev_r)
            hi_len <= run_r;
         else
            lo_len <= run_r;
         run_r <= 8'h01;
      end else
         run_r <= run_r + 8'h01;
      prev_r <= ck[0];
   end
endmodule : gcfp_dram_load

// ### bench/gcfp_top_sva.sv
// port-level assertion checker for the gated clock fanout
module gcfp_top_sva
   import gcfp_pkg::*;
(
   // clock, reset and inputs
   input wire logic                           CLK_SYS,
   input wire logic                           RST,
   input wire logic                           REF_CLK_IN,
   input wire logic                           LOOP_RETURN_CLOCK_IN,
   input wire logic                           ANALOG_SUPPLY_BYPASS_STRAP,
   input wire logic                           BANK_ONE_ENABLE,
   // outputs
   input wire logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_ONE_CLOCK_OUTS,
   input wire logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_TWO_CLOCK_OUTS,
   input wire logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_THREE_CLOCK_OUTS,
   input wire logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_FOUR_CLOCK_OUTS,
   input wire logic                           LOOP_RETURN_CLOCK_OUT,
   input wire logic                           LOCK_OK
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic [SET_W-1:0] calm_r;
   // undisturbed loop cycles, saturating so long runs never wrap
   always_ff @(posedge CLK_SYS) begin
      if (RST || !ANALOG_SUPPLY_BYPASS_STRAP || LOOP_RETURN_CLOCK_IN != LOOP_RETURN_CLOCK_OUT)
         calm_r <= SETTLE_ZERO;
      else if (calm_r != 11'h7FF)
         calm_r <= calm_r + 11'h001;
   end
   a_copies_equal: assert property (BANK_ONE_CLOCK_OUTS inside {4'h0, 4'hF} &&
      BANK_TWO_CLOCK_OUTS inside {4'h0, 4'hF} && BANK_THREE_CLOCK_OUTS inside {4'h0, 4'hF} &&
      BANK_FOUR_CLOCK_OUTS inside {4'h0, 4'hF}) else $error("bank copies differ");
   a_bank_under_fb: assert property (!LOOP_RETURN_CLOCK_OUT |->
      (BANK_ONE_CLOCK_OUTS | BANK_TWO_CLOCK_OUTS | BANK_THREE_CLOCK_OUTS | BANK_FOUR_CLOCK_OUTS) == 4'h0)
      else $error("bank high alone");
   a_enabled_high: assert property (BANK_ONE_ENABLE [*4] ##0 $rose(LOOP_RETURN_CLOCK_OUT) |->
      BANK_ONE_CLOCK_OUTS == 4'hF) else $error("enabled bank missed pulse");
   a_rise_aligned: assert property ($rose(BANK_ONE_CLOCK_OUTS[0]) |->
      $rose(LOOP_RETURN_CLOCK_OUT)) else $error("bank rose off edge");
   a_fall_aligned: assert property ($fell(BANK_ONE_CLOCK_OUTS[0]) |->
      $fell(LOOP_RETURN_CLOCK_OUT)) else $error("bank pulse cut short");
   a_fb_mismatch: assert property (LOOP_RETURN_CLOCK_IN != LOOP_RETURN_CLOCK_OUT |=> !LOCK_OK)
      else $error("lock kept after slip");
   a_bypass_unlocked: assert property (!ANALOG_SUPPLY_BYPASS_STRAP |=> !LOCK_OK)
      else $error("lock in bypass");
   a_bypass_buffer: assert property ((!ANALOG_SUPPLY_BYPASS_STRAP) [*3] |->
      LOOP_RETURN_CLOCK_OUT == $past(REF_CLK_IN, 2)) else $error("bypass not buffered");
   a_settle_first: assert property ($rose(LOCK_OK) |-> calm_r >= SETTLE_LAST)
      else $error("lock before settling");
   a_fb_alive: assert property (LOCK_OK && !LOOP_RETURN_CLOCK_OUT |->
      ##[1:20] LOOP_RETURN_CLOCK_OUT) else $error("feedback stalled");
endmodule : gcfp_top_sva

bind gcfp_top gcfp_top_sva chk (.*);

// ### bench/tb_gated_clock_fanout_pll.sv
// self-checking bench for the gated clock fanout
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_gated_clock_fanout_pll;
   timeunit 1ns;
   timeprecision 1ns;
   import gcfp_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  rst = 1'b1;
   logic                  ref_clk = 1'b0;
   logic                  strap = 1'b1;
   logic                  fb_break = 1'b0;
   logic [3:0]            en = 4'hF;
   logic [2:0]            ref_d = 3'h0;
   logic                  fb_out;
   logic                  lock_ok;
   logic [BANK_WIDTH-1:0] outs [4];
   logic [7:0]            hi_len;
   logic [7:0]            lo_len;
   logic [31:0]           seed = 32'h8068;
   int                    per = 4;
   int                    hi = 1;
   int                    ph = 0;
   int                    miscompares = 0;
   int                    compares = 0;
   always #50 clk_sys = ~clk_sys;
   // reference of chosen period and duty, moved off the sampling edge
   always @(negedge clk_sys) begin
      ph <= (ph + 1 >= per) ? 0 : ph + 1;
      ref_clk <= (ph < hi);
   end
   // reference history for the bypass and phase expectations
   always @(posedge clk_sys) ref_d <= {ref_d[1:0], ref_clk};
   // feedback wired back, break only for the slip case
   gcfp_top dut (.CLK_SYS(clk_sys), .RST(rst), .REF_CLK_IN(ref_clk),
      .LOOP_RETURN_CLOCK_IN(fb_out ^ fb_break), .ANALOG_SUPPLY_BYPASS_STRAP(strap),
      .BANK_ONE_ENABLE(en[0]), .BANK_TWO_ENABLE(en[1]), .BANK_THREE_ENABLE(en[2]),
      .BANK_FOUR_ENABLE(en[3]), .BANK_ONE_CLOCK_OUTS(outs[0]), .BANK_TWO_CLOCK_OUTS(outs[1]),
      .BANK_THREE_CLOCK_OUTS(outs[2]), .BANK_FOUR_CLOCK_OUTS(outs[3]),
      .LOOP_RETURN_CLOCK_OUT(fb_out), .LOCK_OK(lock_ok));
   gcfp_dram_load load (.clk(clk_sys), .ck(outs[0]), .hi_len(hi_len), .lo_len(lo_len));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [BANK_WIDTH-1:0] exp_bank(input logic e, input logic f);
      return (e && f) ? 4'hF : 4'h0;
   endfunction : exp_bank
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   task automatic wait_lock;
      int n;
      n = 0;
      while (lock_ok !== 1'b1 && n < 1500) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("lock", 1'b1, lock_ok)
   endtask : wait_lock
   // bank windows; enables must have settled beforehand
   task automatic check_banks;
      logic saw;
      int   age;
      saw = 1'b0;
      age = -1;
      repeat (2 * per) begin
         @(negedge clk_sys);
         saw |= fb_out;
         // a reference rise two edges back starts a new feedback period
         age = (ref_d[2:1] == 2'b01) ? 0 : ((age < 0) ? -1 : age + 1);
         if (age >= 0) `CHK("fb phase", logic'(age < per / 2), fb_out)
         for (int b = 0; b < 4; b++) `CHK("bank", exp_bank(en[b], fb_out), outs[b])
      end
      `CHK("fb toggling", 1'b1, saw)
   endtask : check_banks
   initial begin
      int pers [4];
      pers = '{4, 5, 8, 7};
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         per = pers[i];
         hi = 1 + int'(seed[7:0]) % (per - 1);
         en = seed[11:8] | 4'h1;
         repeat (20) @(negedge clk_sys);
         `CHK("settling", 1'b0, lock_ok)
         wait_lock();
         repeat (3 * per) @(negedge clk_sys);
         `CHK("high width", 8'(per / 2), hi_len)
         `CHK("low width", 8'(per - per / 2), lo_len)
         check_banks();
      end
      // enable churn; runt-free gating of bank one is judged by the checker
      repeat (200) begin
         @(negedge clk_sys);
         seed = lfsr(seed);
         en = seed[3:0];
      end
      en = 4'h0;
      repeat (per) @(negedge clk_sys);
      check_banks();
      fb_break = 1'b1;
      @(negedge clk_sys);
      fb_break = 1'b0;
      @(negedge clk_sys);
      `CHK("lock after slip", 1'b0, lock_ok)
      wait_lock();
      strap = 1'b0;
      repeat (4) @(negedge clk_sys);
      repeat (20) begin
         @(negedge clk_sys);
         `CHK("bypass fb", ref_d[1], fb_out)
         `CHK("bypass lock", 1'b0, lock_ok)
      end
      complete_run();
   end
   // watchdog: run needs about 5500 cycles
   initial begin
      #(100 * 20000);
      miscompares++;
      complete_run();
   end
endmodule : tb_gated_clock_fanout_pll

// ### core/gcfp_bank_gate.sv
// one bank of four gated clock copies with runt-free enable
module gcfp_bank_gate (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // core clock, enable and outputs
   gcfp_gate_if.gate  gif
);
   import gcfp_pkg::*;

   logic en_held_r;
   logic en_use;
   logic [BANK_WIDTH-1:0] out_r;

   // RULE11 enable moves only while low
   assign en_use = gif.core_clk ? en_held_r : gif.bank_en;

   // held enable, frozen through each high phase
   always_ff @(posedge clk) begin
      if (rst) begin
         en_held_r <= 1'b0;
      end else begin
         en_held_r <= en_use;
      end
   end

   // RULE3 RULE4 four copies, low when gated
   always_ff @(posedge clk) begin
      if (rst) begin
         out_r <= '0;
      end else begin
         out_r <= {BANK_WIDTH{gif.core_clk & en_use}};
      end
   end

   assign gif.bank_out = out_r;

endmodule : gcfp_bank_gate

// ### core/gcfp_top.sv
// gated clock fanout: digital loop, bypass and four gated banks
//
// Operation
// RULE1: sixteen clock copies in four banks
// RULE2: outputs run at fifty percent duty; odd periods here run high half a cycle short
// RULE3: enabled bank follows reference frequency, phase
// RULE4: disabled bank held low, banks independent
// RULE5: feedback output aligned to reference
// RULE6: settling period after reference applied
// RULE7: reference or feedback change restarts settling
// RULE8: bypass mode buffers reference to outputs
// RULE9: feedback output wired straight to input
// RULE10: feedback output always toggles, ignores enables
// RULE11: enable changes take effect only while low
module gcfp_top
   import gcfp_pkg::*;
(
   // system clock and reset
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST,
   // reference clock and loop return
   input  wire logic                      REF_CLK_IN,
   input  wire logic                      LOOP_RETURN_CLOCK_IN,
   // test strap, low bypasses the loop
   input  wire logic                      ANALOG_SUPPLY_BYPASS_STRAP,
   // bank enables
   input  wire logic                      BANK_ONE_ENABLE,
   input  wire logic                      BANK_TWO_ENABLE,
   input  wire logic                      BANK_THREE_ENABLE,
   input  wire logic                      BANK_FOUR_ENABLE,
   // bank clock copies
   output logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_ONE_CLOCK_OUTS,
   output logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_TWO_CLOCK_OUTS,
   output logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_THREE_CLOCK_OUTS,
   output logic [gcfp_pkg::BANK_WIDTH-1:0] BANK_FOUR_CLOCK_OUTS,
   // loop return and lock status
   output logic                           LOOP_RETURN_CLOCK_OUT,
   output logic                           LOCK_OK
);
   import gcfp_pkg::*;

   gcfp_state_t      state_r;
   gcfp_state_t      state_nxt;
   logic             ref_d_r;
   logic             ref_rise;
   logic             seen_edge_r;
   logic             bypass;
   logic [PER_W-1:0] per_cnt_r;
   logic [PER_W-1:0] meas_per_r;
   logic [PER_W-1:0] measured;
   logic [PER_W-1:0] osc_cnt_r;
   logic [PER_W-1:0] osc_cnt_nxt;
   logic [PER_W-1:0] half_per;
   logic             ref_lost;
   logic             freq_change;
   logic             phase_err;
   logic             fb_fault;
   logic             disturb;
   logic [SET_W-1:0] settle_cnt_r;
   logic             core_clk_r;
   logic             loop_return_clock_out_r;
   logic             lock_r;
   logic [NUM_BANKS-1:0] bank_en_vec;
   logic [BANK_WIDTH-1:0] bank_outs [NUM_BANKS];

   // reference is synchronous to the system clock, one stage for edges;
   // reset high so a reference already high at release is not taken as a rise
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ref_d_r <= 1'b1;
      end else begin
         ref_d_r <= REF_CLK_IN;
      end
   end

   assign ref_rise = REF_CLK_IN & ~ref_d_r;
   assign bypass   = (ANALOG_SUPPLY_BYPASS_STRAP == STRAP_BYPASS);
   assign measured = per_cnt_r + PER_ONE;
   assign ref_lost = (per_cnt_r == PER_MAX);

   // cycles since the last reference rise; saturates when the reference stops
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         per_cnt_r <= PER_ZERO;
      end else if (ref_rise) begin
         per_cnt_r <= PER_ZERO;
      end else if (!ref_lost) begin
         per_cnt_r <= per_cnt_r + PER_ONE;
      end
   end

   // first rise only starts the count; the second gives a period
   always_ff @(posedge CLK_SYS) begin
      if (RST || bypass || ref_lost) begin
         seen_edge_r <= 1'b0;
      end else if (ref_rise) begin
         seen_edge_r <= 1'b1;
      end
   end

   // latest measured reference period
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         meas_per_r <= PER_ZERO;
      end else if (ref_rise && seen_edge_r) begin
         meas_per_r <= measured;
      end
   end

   // RULE7 disturbance detection on reference and feedback
   assign freq_change = ref_rise && seen_edge_r && (measured != meas_per_r);
   assign phase_err   = ref_rise && (osc_cnt_r != meas_per_r - PER_ONE);
   // RULE9 relies on output wired back to input
   assign fb_fault    = (LOOP_RETURN_CLOCK_IN != loop_return_clock_out_r);
   assign disturb     = freq_change || phase_err || fb_fault;

   // loop state: acquire period, settle, then locked
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_ACQUIRE: begin
            if (ref_rise && seen_edge_r) begin
               state_nxt = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // RULE6 lock only after full settling
            if (!disturb && settle_cnt_r == SETTLE_LAST) begin
               state_nxt = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (disturb) begin
               state_nxt = ST_SETTLE;
            end
         end
      endcase
      // stopped reference or bypass drops back to acquisition
      if (bypass || ref_lost) begin
         state_nxt = ST_ACQUIRE;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_r <= ST_ACQUIRE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // RULE7 settling counter restarts on any disturbance
   always_ff @(posedge CLK_SYS) begin
      if (RST || state_r != ST_SETTLE || disturb) begin
         settle_cnt_r <= SETTLE_ZERO;
      end else if (settle_cnt_r != SETTLE_LAST) begin
         settle_cnt_r <= settle_cnt_r + SET_W'(1);
      end
   end

   // RULE5 oscillator snaps its phase to each reference rise
   always_comb begin
      if (ref_rise || osc_cnt_r >= meas_per_r - PER_ONE) begin
         osc_cnt_nxt = PER_ZERO;
      end else begin
         osc_cnt_nxt = osc_cnt_r + PER_ONE;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || state_r == ST_ACQUIRE) begin
         osc_cnt_r <= PER_ZERO;
      end else begin
         osc_cnt_r <= osc_cnt_nxt;
      end
   end

   // RULE2 high for half the period; odd periods lose half a cycle
   assign half_per = meas_per_r >> 1;

   // core clock: regenerated, or the buffered reference in bypass
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         core_clk_r <= 1'b0;
      end else if (bypass) begin
         // RULE8 reference passed straight through
         core_clk_r <= REF_CLK_IN;
      end else if (state_r == ST_ACQUIRE && !(ref_rise && seen_edge_r)) begin
         core_clk_r <= 1'b0;
      end else begin
         core_clk_r <= (osc_cnt_nxt < half_per);
      end
   end

   // RULE10 feedback copy ignores all bank enables
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         loop_return_clock_out_r <= 1'b0;
      end else begin
         loop_return_clock_out_r <= core_clk_r;
      end
   end

   // lock flag, never claimed in bypass
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         lock_r <= 1'b0;
      end else begin
         lock_r <= (state_nxt == ST_LOCKED);
      end
   end

   assign bank_en_vec = {BANK_FOUR_ENABLE, BANK_THREE_ENABLE, BANK_TWO_ENABLE, BANK_ONE_ENABLE};

   // RULE1 four banks of four gated copies
   generate
      for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
         gcfp_gate_if gif ();

         assign gif.core_clk = core_clk_r;
         assign gif.bank_en  = bank_en_vec[b];
         assign bank_outs[b] = gif.bank_out;

         gcfp_bank_gate u_gate (
            .clk (CLK_SYS),
            .rst (RST),
            .gif (gif.gate)
         );
      end
   endgenerate

   // outputs, each from a flop in the bank gates or above
   assign BANK_ONE_CLOCK_OUTS   = bank_outs[0];
   assign BANK_TWO_CLOCK_OUTS   = bank_outs[1];
   assign BANK_THREE_CLOCK_OUTS = bank_outs[2];
   assign BANK_FOUR_CLOCK_OUTS  = bank_outs[3];
   assign LOOP_RETURN_CLOCK_OUT = loop_return_clock_out_r;
   assign LOCK_OK               = lock_r;

endmodule : gcfp_top

// ### include/gcfp_gate_if.sv
// carrier between the loop core and one bank gate
interface gcfp_gate_if;
   import gcfp_pkg::*;

   logic                  core_clk;
   logic                  bank_en;
   logic [BANK_WIDTH-1:0] bank_out;

   modport ctrl (output core_clk, output bank_en, input bank_out);
   modport gate (input core_clk, input bank_en, output bank_out);
endinterface : gcfp_gate_if

// ### include/gcfp_pkg.sv
// constants and types for the gated clock fanout with digital loop
package gcfp_pkg;

   // fanout shape
   localparam int NUM_BANKS  = 4;
   localparam int BANK_WIDTH = 4;

   // system clock rate
   localparam longint CLK_SYS_HZ = 64'h989680;  // ten megahertz

   // settling time after any disturbance, in microseconds
   localparam longint SETTLE_TIME_US = 64'h64;  // one hundred microseconds
   // least time, so the cycle count rounds up (one million microseconds a second)
   localparam longint SETTLE_CYC_L   = (SETTLE_TIME_US * CLK_SYS_HZ + 64'hF423F) / 64'hF4240;
   localparam int     SET_W          = 11;
   localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYC_L - 64'd1);
   localparam logic [SET_W-1:0] SETTLE_ZERO = 11'h000;

   // reference period measurement
   localparam int              PER_W    = 16;
   localparam logic [PER_W-1:0] PER_ZERO = 16'h0000;
   localparam logic [PER_W-1:0] PER_ONE  = 16'h0001;
   localparam logic [PER_W-1:0] PER_MAX  = 16'hFFFF;

   // bypass strap level that selects the test bypass (strapped to ground)
   localparam logic STRAP_BYPASS = 1'b0;

   // loop state
   typedef enum logic [1:0] {
      ST_ACQUIRE,
      ST_SETTLE,
      ST_LOCKED
   } gcfp_state_t;

endpackage : gcfp_pkg
